// ### adc_pwr_pkg.sv
// Shared types and constants for the converter power-mode sequencer
`default_nettype none
package adc_pwr_pkg;
  localparam int          RES_W           = 12;
  localparam int          CNT_W           = 6;
  localparam logic [5:0]  GLITCH_EDGES    = 6'h02;
  localparam logic [5:0]  POWER_EDGES     = 6'h0a;
  localparam logic [5:0]  RESULT_EDGES    = 6'h0e;
  localparam logic [5:0]  DUAL_EDGES      = 6'h20;
  localparam logic [3:0]  LEAD_ZEROS      = 4'h2;
  localparam logic [3:0]  DATA_END        = 4'h0d;
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          WAKE_PARTIAL_NS = 1000;
  localparam int          WAKE_DEEP_NS    = 1500000;
  localparam int          WAKE_PARTIAL_CYC = WAKE_PARTIAL_NS / CLK_PERIOD_NS;
  localparam int          WAKE_DEEP_CYC    = WAKE_DEEP_NS / CLK_PERIOD_NS;
  localparam int          WAKE_W          = 14;
  localparam int          BUF_DEPTH       = 2;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PARTIAL,
    MODE_FULL
  } pwr_mode_t;

  typedef struct packed {
    logic [RES_W-1:0] res_first;
    logic [RES_W-1:0] res_second;
  } result_pair_t;

  typedef struct packed {
    logic dout;
    logic oe;
  } serial_pin_t;
endpackage : adc_pwr_pkg
`default_nettype wire

// ### result_buffer.sv
// Two-entry valid/ready buffer for converter result pairs
`default_nettype none
module result_buffer
  import adc_pwr_pkg::*;
#(
  parameter int WIDTH = 2 * RES_W,
  parameter int DEPTH = BUF_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      level_r;
  logic             push;
  logic             pop;

  assign in_ready  = (level_r != (PW+1)'(DEPTH));
  assign out_valid = (level_r != '0);
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        level_r <= level_r + 1'b1;
      end else if (pop && !push) begin
        level_r <= level_r - 1'b1;
      end
    end
  end
endmodule : result_buffer
`default_nettype wire

// ### adc_power_mode_sequencer.sv
// Chip-select driven power-mode sequencer with dual serial data outputs
`default_nettype none
module adc_power_mode_sequencer
  import adc_pwr_pkg::*;
#(
  parameter int DEEP_WAKE_CYCLES = WAKE_DEEP_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         cs_n_pin,
  input  wire logic         sclk_pin,
  input  wire logic         result_valid,
  output var  logic         result_ready,
  input  wire result_pair_t result_data,
  output var  logic         sample_r,
  output var  serial_pin_t  serial_out_first,
  output var  serial_pin_t  serial_out_second,
  output var  logic         analog_en_r,
  output var  logic         ref_en_r,
  output var  logic         power_ready_r,
  output var  pwr_mode_t    mode_r
);
  localparam logic [WAKE_W-1:0] WAKE_P = WAKE_W'(WAKE_PARTIAL_CYC);
  localparam logic [WAKE_W-1:0] WAKE_D = WAKE_W'(DEEP_WAKE_CYCLES);

  logic             cs_s1_r;
  logic             cs_s2_r;
  logic             cs_d_r;
  logic             sclk_s1_r;
  logic             sclk_s2_r;
  logic             sclk_d_r;
  logic             cs_fall;
  logic             cs_rise;
  logic             sclk_fall;
  logic             in_frame_r;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] count_nxt;
  logic             edge_take;
  result_pair_t     word_r;
  logic             head_valid;
  result_pair_t     head_data;
  pwr_mode_t        mode_nxt;
  logic [WAKE_W-1:0] wake_cnt_r;

  // Mode chosen at select rise from the edge count seen in the frame
  function automatic pwr_mode_t next_mode(input pwr_mode_t m, input logic [CNT_W-1:0] n);
    pwr_mode_t r;
    r = m;
    if (n >= POWER_EDGES) begin
      r = MODE_NORMAL;
    end else if (n >= GLITCH_EDGES) begin
      r = (m == MODE_NORMAL) ? MODE_PARTIAL : MODE_FULL;
    end
    return r;
  endfunction : next_mode

  // Bit presented after n counted edges; each 16-edge half holds one result
  function automatic logic frame_bit(input logic [CNT_W-1:0] n, input result_pair_t w,
                                     input logic second_line);
    logic [3:0]       k;
    logic [RES_W-1:0] d;
    k = n[3:0];
    d = (n[4] ^ second_line) ? w.res_second : w.res_first;
    if (k < LEAD_ZEROS || k > DATA_END) begin
      return 1'b0;
    end
    return d[DATA_END - k];
  endfunction : frame_bit

  // Pins come from the host's domain, so two flops before any use
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1_r   <= 1'b1;
      cs_s2_r   <= 1'b1;
      cs_d_r    <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r  <= 1'b0;
    end else begin
      cs_s1_r   <= cs_n_pin;
      cs_s2_r   <= cs_s1_r;
      cs_d_r    <= cs_s2_r;
      sclk_s1_r <= sclk_pin;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r  <= sclk_s2_r;
    end
  end

  assign cs_fall   = cs_d_r && !cs_s2_r;
  assign cs_rise   = !cs_d_r && cs_s2_r && in_frame_r;
  assign sclk_fall = sclk_d_r && !sclk_s2_r;
  // A clock fall in the select-fall cycle is not a counted edge
  assign edge_take = sclk_fall && in_frame_r && !cs_fall && !cs_rise;
  assign count_nxt = count_r + 1'b1;
  assign mode_nxt  = next_mode(mode_r, count_r);

  result_buffer #(
    .WIDTH ($bits(result_pair_t)),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   (result_data),
    .out_valid (head_valid),
    .out_ready (cs_fall),
    .out_data  (head_data)
  );

  // Frame tracking and edge count
  always_ff @(posedge clk) begin
    if (rst) begin
      in_frame_r <= 1'b0;
      count_r    <= '0;
    end else if (cs_fall) begin
      in_frame_r <= 1'b1;
      count_r    <= '0;
    end else if (cs_rise) begin
      in_frame_r <= 1'b0;
    end else if (edge_take && count_r != DUAL_EDGES) begin
      count_r    <= count_nxt;
    end
  end

  // Word shifted in this frame; an empty buffer gives zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= '0;
    end else if (cs_fall) begin
      word_r <= head_valid ? head_data : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sample_r <= 1'b0;
    end else begin
      sample_r <= cs_fall;
    end
  end

  // Serial lines: leading zero at select fall, then one bit per counted edge
  always_ff @(posedge clk) begin
    if (rst) begin
      serial_out_first  <= '0;
      serial_out_second <= '0;
    end else if (cs_fall) begin
      serial_out_first  <= '{dout: 1'b0, oe: 1'b1};
      serial_out_second <= '{dout: 1'b0, oe: 1'b1};
    end else if (cs_rise) begin
      serial_out_first.oe  <= 1'b0;
      serial_out_second.oe <= 1'b0;
    end else if (edge_take && count_r != DUAL_EDGES) begin
      if (count_nxt == DUAL_EDGES) begin
        serial_out_first.oe  <= 1'b0;
        serial_out_second.oe <= 1'b0;
      end
      // Past edge 13 the lines stay driven with zeros, then the other result
      serial_out_first.dout  <= frame_bit(count_nxt, word_r, 1'b0);
      serial_out_second.dout <= frame_bit(count_nxt, word_r, 1'b1);
    end
  end

  // Power-on mode is unknown in silicon; normal is the safe reset choice
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= MODE_NORMAL;
    end else if (cs_rise) begin
      mode_r <= mode_nxt;
    end
  end

  // Power-up starts on select fall and is dropped again at an early rise
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_en_r <= 1'b1;
      ref_en_r    <= 1'b1;
    end else begin
      analog_en_r <= (mode_r == MODE_NORMAL) || in_frame_r;
      ref_en_r    <= (mode_r != MODE_FULL) || in_frame_r;
    end
  end

  // Settling timer; the deep figure is long, so it is a parameter
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_cnt_r <= '0;
    end else if (cs_fall && mode_r != MODE_NORMAL) begin
      wake_cnt_r <= (mode_r == MODE_FULL) ? WAKE_D : WAKE_P;
    end else if (wake_cnt_r != '0) begin
      wake_cnt_r <= wake_cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      power_ready_r <= 1'b1;
    end else begin
      power_ready_r <= (mode_r == MODE_NORMAL) && (wake_cnt_r == '0);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_rise_from(pwr_mode_t m, int lo, int hi);
    cs_rise && mode_r == m && count_r >= CNT_W'(lo) && count_r <= CNT_W'(hi);
  endsequence

  sequence s_tristated;
    !serial_out_first.oe && !serial_out_second.oe;
  endsequence

  property p_fall_starts;
    cs_fall |=> sample_r && serial_out_first.oe && serial_out_second.oe
                && !serial_out_first.dout && count_r == '0;
  endproperty
  a_fall_starts: assert property (p_fall_starts) else $error("frame start wrong");

  property p_coincident;
    cs_fall && sclk_fall |=> count_r == '0;
  endproperty
  a_coincident: assert property (p_coincident) else $error("coincident edge counted");

  property p_count_step;
    edge_take && count_r < DUAL_EDGES |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("edge count wrong");

  property p_late_abort;
    s_rise_from(MODE_NORMAL, 10, 13) |=> (mode_r == MODE_NORMAL) and s_tristated;
  endproperty
  a_late_abort: assert property (p_late_abort) else $error("late abort wrong");

  property p_hold_drive;
    in_frame_r && count_r >= RESULT_EDGES && count_r < DUAL_EDGES - 1'b1 && !cs_rise
      |=> serial_out_first.oe && serial_out_second.oe;
  endproperty
  a_hold_drive: assert property (p_hold_drive) else $error("output released early");

  property p_trailing;
    edge_take && (count_r == 6'h0d || count_r == 6'h0e) |=> !serial_out_first.dout;
  endproperty
  a_trailing: assert property (p_trailing) else $error("trailing bit not zero");

  property p_other_result;
    edge_take && count_r == 6'h11 |=> serial_out_first.dout == word_r.res_second[RES_W-1]
                                     && serial_out_second.dout == word_r.res_first[RES_W-1];
  endproperty
  a_other_result: assert property (p_other_result) else $error("second result bad");

  property p_end_release;
    edge_take && count_r == 6'h1f |=> s_tristated;
  endproperty
  a_end_release: assert property (p_end_release) else $error("no release at edge 32");

  property p_enter_partial;
    s_rise_from(MODE_NORMAL, 2, 9) |=> ((mode_r == MODE_PARTIAL) and s_tristated)
                                     ##1 (!analog_en_r && ref_en_r);
  endproperty
  a_enter_partial: assert property (p_enter_partial) else $error("partial entry bad");

  property p_glitch_normal;
    s_rise_from(MODE_NORMAL, 0, 1) |=> mode_r == MODE_NORMAL;
  endproperty
  a_glitch_normal: assert property (p_glitch_normal) else $error("glitch changed mode");

  property p_partial_wake;
    s_rise_from(MODE_PARTIAL, 10, 32) |=> mode_r == MODE_NORMAL;
  endproperty
  a_partial_wake: assert property (p_partial_wake) else $error("no wake");

  property p_partial_glitch;
    s_rise_from(MODE_PARTIAL, 0, 1) |=> mode_r == MODE_PARTIAL ##1 !analog_en_r;
  endproperty
  a_partial_glitch: assert property (p_partial_glitch) else $error("glitch woke part");

  property p_enter_full;
    s_rise_from(MODE_PARTIAL, 2, 9) |=> mode_r == MODE_FULL ##1 !analog_en_r && !ref_en_r;
  endproperty
  a_enter_full: assert property (p_enter_full) else $error("full entry bad");
endmodule : adc_power_mode_sequencer
`default_nettype wire

// ### host_link_model.sv
// Host serial-port model driving chip select and the serial clock
`default_nettype none
module host_link_model
  import adc_pwr_pkg::*;
(
  input  wire logic        clk,
  input  wire serial_pin_t line_a,
  input  wire serial_pin_t line_b,
  output var  logic        cs_n_pin,
  output var  logic        sclk_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] bits_a;
  logic [31:0] bits_b;
  logic [1:0]  oe_start;
  logic [1:0]  oe_rise;
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
  end
  // Half link period is four system clocks; clock idles low between frames
  task automatic frame(input int n, input bit coin);
    if (coin) begin
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
    end
    cs_n_pin <= 1'b0;
    repeat (8) @(posedge clk);
    oe_start = {line_a.oe, line_b.oe};
    for (int i = 0; i < n; i++) begin
      sclk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      sclk_pin <= 1'b0;
      // Output moves three edges after the fall; read just before the next rise
      repeat (4) @(posedge clk);
      bits_a[i] = line_a.dout;
      bits_b[i] = line_b.dout;
    end
    oe_rise = {line_a.oe, line_b.oe};
    cs_n_pin <= 1'b1;
    repeat (6) @(posedge clk);
  endtask : frame
endmodule : host_link_model
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the power-mode sequencer
`default_nettype none
module tb_top
  import adc_pwr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // Deep wake shortened, yet longer than any frame so the wait is visible
  localparam int DEEP = 300;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         result_valid = 1'b0;
  result_pair_t result_data = '0;
  logic         result_ready;
  logic         cs_n_pin;
  logic         sclk_pin;
  logic         sample_r;
  logic         analog_en_r;
  logic         ref_en_r;
  logic         power_ready_r;
  serial_pin_t  serial_out_first;
  serial_pin_t  serial_out_second;
  pwr_mode_t    mode_r;
  pwr_mode_t    cur = MODE_NORMAL;
  result_pair_t exp_q[$];
  int           fails = 0;
  int           n_compared = 0;
  int           cycles = 0;
  int           samples = 0;
  int           nfr = 0;
  always #50 clk = ~clk;
  adc_power_mode_sequencer #(.DEEP_WAKE_CYCLES(DEEP)) dut (
    .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .result_valid(result_valid), .result_ready(result_ready), .result_data(result_data),
    .sample_r(sample_r), .serial_out_first(serial_out_first),
    .serial_out_second(serial_out_second), .analog_en_r(analog_en_r), .ref_en_r(ref_en_r),
    .power_ready_r(power_ready_r), .mode_r(mode_r));
  host_link_model host (
    .clk(clk), .line_a(serial_out_first), .line_b(serial_out_second),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin));
  task automatic complete_run();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (sample_r === 1'b1) samples++;
    if (cycles > 40000) begin
      fails++;
      complete_run();
    end
  end
  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check_bit
  task automatic check_mode(input pwr_mode_t got, input pwr_mode_t exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check_mode
  function automatic pwr_mode_t next_mode(pwr_mode_t m, int n);
    if (n >= 10) return MODE_NORMAL;
    if (n < 2 || m == MODE_FULL) return m;
    return (m == MODE_NORMAL) ? MODE_PARTIAL : MODE_FULL;
  endfunction : next_mode
  function automatic logic exp_bit(result_pair_t w, int n, bit line);
    int k;
    logic [RES_W-1:0] v;
    k = n % 16;
    v = ((n >= 16) ^ line) ? w.res_second : w.res_first;
    if (k < 2 || k > 13) return 1'b0;
    return v[13-k];
  endfunction : exp_bit
  task automatic push();
    result_pair_t w;
    int t;
    w = 24'($urandom);
    @(posedge clk);
    result_valid <= 1'b1;
    result_data <= w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (result_ready !== 1'b1 && t < 50);
    result_valid <= 1'b0;
    exp_q.push_back(w);
  endtask : push
  task automatic run(input int n, input bit coin);
    result_pair_t w;
    pwr_mode_t m;
    w = '0;
    if (exp_q.size() > 0) w = exp_q.pop_front();
    m = cur;
    host.frame(n, coin);
    cur = next_mode(m, n);
    nfr++;
    check_bit(&host.oe_start, 1'b1);
    for (int i = 0; i < n && i < 31; i++) begin
      check_bit(host.bits_a[i], exp_bit(w, i + 1, 1'b0));
      check_bit(host.bits_b[i], exp_bit(w, i + 1, 1'b1));
    end
    check_bit(host.oe_rise[1], n < 32);
    check_bit(serial_out_first.oe | serial_out_second.oe, 1'b0);
    check_mode(mode_r, cur);
    check_bit(analog_en_r, cur == MODE_NORMAL);
    check_bit(ref_en_r, cur != MODE_FULL);
    check_bit(power_ready_r, cur == MODE_NORMAL && m != MODE_FULL);
    if (m == MODE_FULL && cur == MODE_NORMAL) begin
      repeat (DEEP) @(posedge clk);
      check_bit(power_ready_r, 1'b1);
    end
  endtask : run
  initial begin
    int seq[19];
    int n;
    seq = '{0, 1, 5, 1, 9, 2, 1, 10, 2, 12, 2, 8, 3, 13, 11, 32, 31, 15, 17};
    n = $urandom(15573);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    push();
    push();
    // Third word offered while full must be held off
    @(posedge clk);
    result_valid <= 1'b1;
    repeat (2) @(posedge clk);
    check_bit(result_ready, 1'b0);
    result_valid <= 1'b0;
    run(16, 1'b0);
    foreach (seq[i]) begin
      if (i % 5 != 4) push();
      run(seq[i], i % 3 == 0);
    end
    repeat (20) begin
      if ($urandom % 4 != 0) push();
      run($urandom % 33, $urandom % 2);
    end
    check_bit(samples == nfr, 1'b1);
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
